// >>> mic_core_model.sv
// core model: issues instruction pulses, tracks vectors, stack and wakes
`timescale 1ns/1ps
module mic_core_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       vec_req,
   input  wire logic       push_ret,
   input  wire logic [9:0] vec_addr,
   input  wire logic       wake,
   output logic      [4:0] instr
);
   // ************************************************************
   // fetch and stack tracking
   // ************************************************************
   int         depth    = 0;
   int         vec_cnt  = 0;
   int         wake_cnt = 0;
   logic [9:0] last_vec = 10'h000;
   logic [4:0] nxt      = 5'h00;
   initial instr = 5'h00;
   // decode lines come from a flop, as the real core's decode stage would
   always @(posedge clk)
      instr <= nxt;
   // a redirect pushes one return address and lands on the vector
   always @(posedge clk) begin
      if (!rst && vec_req) begin
         depth = depth + int'(push_ret);
         vec_cnt = vec_cnt + 1;
         last_vec = vec_addr;
      end
      if (!rst && wake)
         wake_cnt = wake_cnt + 1;
   end
   // one-cycle pulse, two edges after the request:
   // 0 on, 1 off, 2 return, 3 sleep, 4 trap
   task issue(input int k);
      @(posedge clk);
      nxt <= 5'h01 << k;
      @(posedge clk);
      nxt <= 5'h00;
      if (k == 2)
         depth = depth - 1;
   endtask : issue
endmodule : mic_core_model

// >>> mic_irq_ctrl.sv
// interrupt controller top: flags, masks, vectoring, sleep wake-up
//
// What this block does
// - three sources: timer overflow (falling edge), port change (any change), external pin (falling edge)
// - input pins raise port change; outputs and alternate pin 0 never do
// - port change wakes from sleep only if enabled before sleep
// - after wake: continue in line if global off, else vector 008H
// - one flag bit per request, one mask bit per source
// - enable instruction sets global enable, disable instruction clears it
// - enabled interrupt with global enable on fetches from 008H
// - timer and external flags set regardless of mask or global enable
// - effective request is flag AND mask per source
// - return-from-interrupt ends routine and sets global enable
// - trap instruction with interrupts enabled fetches from 001H
`timescale 1ns/1ps

module mic_irq_ctrl #(
   parameter int PORT_W = 8
) (
   input  wire logic                      CLK_SYS,
   input  wire logic                      SYS_RST,
   // ahb-lite slave
   input  wire logic                      HSEL,
   input  wire logic [31:0]               HADDR,
   input  wire logic [1:0]                HTRANS,
   input  wire logic                      HWRITE,
   input  wire logic [2:0]                HSIZE,
   input  wire logic [31:0]               HWDATA,
   input  wire logic                      HREADY,
   output logic      [31:0]               HRDATA,
   output logic                           HREADYOUT,
   output logic                           HRESP,
   // event sources
   input  wire logic                      TIMER_OVF,
   input  wire logic [PORT_W-1:0]         PORT_PIN,
   // core instruction decode
   input  wire logic                      GLOBAL_IRQ_ON_INSTR,
   input  wire logic                      GLOBAL_IRQ_OFF_INSTR,
   input  wire logic                      RETURN_FROM_ISR_INSTR,
   input  wire logic                      SLEEP_INSTR,
   input  wire logic                      TRAP_INSTR,
   // core fetch and stack
   output logic                           VEC_REQ,
   output logic      [mic_pkg::MIC_PC_W-1:0] VEC_ADDR,
   output logic                           PUSH_RET,
   output logic                           WAKE,
   output logic                           SLEEPING,
   output logic                           GIE,
   output logic      [mic_pkg::MIC_SRC_NUM-1:0] IRQ_ACTIVE
);
   import mic_pkg::*;

   // ************************************************************
   // elaboration checks
   // ************************************************************
   if (PORT_W < 2 || PORT_W > 8) begin : g_chk
      $error("PORT_W must lie between 2 and 8");
   end

   // one register hit, used for read and write decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   // ************************************************************
   // state
   // ************************************************************
   logic [MIC_SRC_NUM-1:0] flag_q, flag_d;
   logic [MIC_SRC_NUM-1:0] mask_q;
   logic [MIC_SRC_NUM-1:0] pend;
   logic [PORT_W-1:0]      dir_q;      // 1 = input
   logic                   alt_q;
   logic [PORT_W-1:0]      sync1_q, sync2_q, ref_q;
   logic                   tmr_prev_q, ext_prev_q;
   logic                   tmr_fall, ext_fall, pchg;
   logic                   gie_q, arm_q;
   mic_state_type          state_q;
   logic                   wr_pend_q;
   logic [7:0]             wr_addr_q;
   logic                   acc, rd_acc, wr_flag, wr_mask;
   logic [31:0]            rd_mux;
   logic                   take_irq, take_trap, wake_now;
   logic [PORT_W-1:0]      chg_en;

   // ************************************************************
   // pin synchroniser and edge detection
   // ************************************************************
   // two flops on every port pin; only sync2_q feeds logic
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= PORT_PIN;
         sync2_q <= sync1_q;
      end
   end

   // previous levels for falling-edge detection
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         tmr_prev_q <= 1'b0;
         ext_prev_q <= 1'b1;
      end else begin
         tmr_prev_q <= TIMER_OVF;
         ext_prev_q <= sync2_q[0];
      end
   end

   assign tmr_fall = tmr_prev_q & ~TIMER_OVF;
   assign ext_fall = alt_q & ext_prev_q & ~sync2_q[0];

   // per-pin change enable: inputs only, alternate pin 0 excluded
   generate
      for (genvar i = 0; i < PORT_W; i++) begin : g_chg
         if (i == 0) begin : g_p0
            assign chg_en[i] = dir_q[i] & ~alt_q;
         end else begin : g_pn
            assign chg_en[i] = dir_q[i];
         end
      end
   endgenerate

   // a change is any input pin differing from the last port read
   assign pchg = |((sync2_q ^ ref_q) & chg_en);

   // ************************************************************
   // ahb-lite slave, zero wait states
   // ************************************************************
   assign acc     = HSEL & HREADY & HTRANS[1];
   assign rd_acc  = acc & ~HWRITE;
   assign wr_flag = wr_pend_q & hit(wr_addr_q, MIC_OFS_FLAG);
   assign wr_mask = wr_pend_q & hit(wr_addr_q, MIC_OFS_MASK);

   // read mux; unmapped words read as zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit(HADDR[7:0], MIC_OFS_FLAG)) begin
         rd_mux[MIC_SRC_NUM-1:0] = flag_q;
      end else if (hit(HADDR[7:0], MIC_OFS_MASK)) begin
         rd_mux[MIC_SRC_NUM-1:0] = mask_q;
      end else if (hit(HADDR[7:0], MIC_OFS_PCFG)) begin
         rd_mux[PORT_W-1:0]  = dir_q;
         rd_mux[MIC_BIT_ALT] = alt_q;
      end else if (hit(HADDR[7:0], MIC_OFS_STAT)) begin
         rd_mux[MIC_BIT_GIE] = gie_q;
         rd_mux[MIC_BIT_SLP] = (state_q == MIC_ST_SLEEP);
         rd_mux[MIC_BIT_ARM] = arm_q;
      end else if (hit(HADDR[7:0], MIC_OFS_PORT)) begin
         rd_mux[PORT_W-1:0] = sync2_q;
      end
   end

   // read data set up in the address phase so it stands in the data phase
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         HRDATA <= 32'h0000_0000;
      end else if (rd_acc) begin
         HRDATA <= rd_mux;
      end
   end

   // write address held over to the data phase
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= acc & HWRITE;
         wr_addr_q <= HADDR[7:0];
      end
   end

   // never stalls, never errors
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
   end

   // ************************************************************
   // configuration registers
   // ************************************************************
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         mask_q <= MIC_RST_MASK;
      end else if (wr_mask) begin
         mask_q <= HWDATA[MIC_SRC_NUM-1:0];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         dir_q <= MIC_RST_DIR[PORT_W-1:0];
         alt_q <= MIC_RST_ALT;
      end else if (wr_pend_q && hit(wr_addr_q, MIC_OFS_PCFG)) begin
         dir_q <= HWDATA[PORT_W-1:0];
         alt_q <= HWDATA[MIC_BIT_ALT];
      end
   end

   // a port read refreshes the change reference (software duty before
   // enabling the port change source)
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         ref_q <= '0;
      end else if (rd_acc && hit(HADDR[7:0], MIC_OFS_PORT)) begin
         ref_q <= sync2_q;
      end
   end

   // ************************************************************
   // flag register
   // ************************************************************
   // writing 0 clears a flag (service routine duty); a new event in the
   // same cycle wins so no request is lost
   always_comb begin
      flag_d = flag_q;
      if (wr_flag) begin
         flag_d = flag_q & HWDATA[MIC_SRC_NUM-1:0];
      end
      if (tmr_fall) begin
         flag_d[MIC_BIT_TMR] = 1'b1;
      end
      if (ext_fall) begin
         flag_d[MIC_BIT_EXT] = 1'b1;
      end
      // port change latches only while its mask bit is on
      if (pchg && mask_q[MIC_BIT_PCHG]) begin
         flag_d[MIC_BIT_PCHG] = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         flag_q <= MIC_RST_FLAG;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign pend = flag_q & mask_q;

   // ************************************************************
   // sleep and wake
   // ************************************************************
   // wake only from a source armed at the moment of sleep
   assign wake_now = (state_q == MIC_ST_SLEEP) & arm_q & pchg;

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         state_q <= MIC_ST_RUN;
         arm_q   <= 1'b0;
      end else begin
         case (state_q)
            MIC_ST_RUN: begin
               if (SLEEP_INSTR) begin
                  state_q <= MIC_ST_SLEEP;
                  arm_q   <= mask_q[MIC_BIT_PCHG];
               end
            end
            MIC_ST_SLEEP: begin
               if (wake_now) begin
                  state_q <= MIC_ST_RUN;
                  arm_q   <= 1'b0;
               end
            end
            default: begin
               state_q <= MIC_ST_RUN;
               arm_q   <= 1'b0;
            end
         endcase
      end
   end

   // ************************************************************
   // global enable and vectoring
   // ************************************************************
   // a pending request outranks a trap in the same cycle; the trap is
   // dropped then, as the core is already being redirected
   assign take_irq  = gie_q & (|pend) & (state_q == MIC_ST_RUN)
                      & ~VEC_REQ;
   assign take_trap = gie_q & TRAP_INSTR & ~take_irq
                      & (state_q == MIC_ST_RUN) & ~VEC_REQ;

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         gie_q <= 1'b0;
      end else if (take_irq || take_trap) begin
         gie_q <= 1'b0;
      end else if (GLOBAL_IRQ_ON_INSTR || RETURN_FROM_ISR_INSTR) begin
         gie_q <= 1'b1;
      end else if (GLOBAL_IRQ_OFF_INSTR) begin
         gie_q <= 1'b0;
      end
   end

   // vector request and stack push, one cycle each; address held until the next vector
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         VEC_REQ  <= 1'b0;
         PUSH_RET <= 1'b0;
         VEC_ADDR <= MIC_VEC_IRQ;
      end else begin
         VEC_REQ  <= take_irq | take_trap;
         PUSH_RET <= take_irq | take_trap;
         if (take_irq) begin
            VEC_ADDR <= MIC_VEC_IRQ;
         end else if (take_trap) begin
            VEC_ADDR <= MIC_VEC_TRAP;
         end
      end
   end

   // core-facing levels and the wake pulse
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         WAKE       <= 1'b0;
         SLEEPING   <= 1'b0;
         GIE        <= 1'b0;
         IRQ_ACTIVE <= '0;
      end else begin
         // after waking the core runs in line; vectoring follows from the
         // pending port change if the global enable is on
         WAKE       <= wake_now;
         SLEEPING   <= (state_q == MIC_ST_SLEEP) ? ~wake_now : SLEEP_INSTR;
         GIE        <= gie_q;
         IRQ_ACTIVE <= pend;
      end
   end

endmodule : mic_irq_ctrl

// >>> mic_irq_ctrl_sva.sv
// checker of vectoring, global enable and wake-up behaviour
`timescale 1ns/1ps
module mic_irq_ctrl_sva
   import mic_pkg::*;
(
   input wire logic                         CLK_SYS,
   input wire logic                         SYS_RST,
   input wire logic                         HREADYOUT,
   input wire logic                         HRESP,
   input wire logic                         GLOBAL_IRQ_ON_INSTR,
   input wire logic                         GLOBAL_IRQ_OFF_INSTR,
   input wire logic                         RETURN_FROM_ISR_INSTR,
   input wire logic                         TRAP_INSTR,
   input wire logic                         VEC_REQ,
   input wire logic [mic_pkg::MIC_PC_W-1:0] VEC_ADDR,
   input wire logic                         PUSH_RET,
   input wire logic                         WAKE,
   input wire logic                         SLEEPING,
   input wire logic                         GIE
);
   // ************************************************************
   // properties
   // ************************************************************
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);
   // global enable output lags the internal bit by one cycle
   sequence gie_up_s;
      1'b1 ##1 GIE;
   endsequence
   bus_okay_a: assert property (HREADYOUT && !HRESP)
      else $error("bus not ready or error");
   vec_push_a: assert property (VEC_REQ |-> PUSH_RET)
      else $error("vector without push");
   vec_pulse_a: assert property (VEC_REQ |=> !VEC_REQ && !PUSH_RET)
      else $error("vector longer than one cycle");
   vec_gie_a: assert property (VEC_REQ |=> !GIE)
      else $error("global enable kept after vector");
   vec_addr_a: assert property (VEC_REQ |->
      VEC_ADDR == MIC_VEC_IRQ || $past(TRAP_INSTR))
      else $error("vector address without cause");
   gie_on_a: assert property (
      GLOBAL_IRQ_ON_INSTR |=> VEC_REQ or gie_up_s)
      else $error("enable instruction lost");
   gie_ret_a: assert property (
      RETURN_FROM_ISR_INSTR |=> VEC_REQ or gie_up_s)
      else $error("return did not enable");
   gie_off_a: assert property (GLOBAL_IRQ_OFF_INSTR &&
      !GLOBAL_IRQ_ON_INSTR && !RETURN_FROM_ISR_INSTR |-> ##2 !GIE)
      else $error("disable instruction lost");
   gie_rise_a: assert property ($rose(GIE) |->
      $past(GLOBAL_IRQ_ON_INSTR, 2) || $past(RETURN_FROM_ISR_INSTR, 2))
      else $error("global enable rose without cause");
   wake_end_a: assert property (WAKE |-> !SLEEPING && $past(SLEEPING))
      else $error("wake outside sleep");
endmodule : mic_irq_ctrl_sva

bind mic_irq_ctrl mic_irq_ctrl_sva u_sva (.CLK_SYS(CLK_SYS),
   .SYS_RST(SYS_RST), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .GLOBAL_IRQ_ON_INSTR(GLOBAL_IRQ_ON_INSTR),
   .GLOBAL_IRQ_OFF_INSTR(GLOBAL_IRQ_OFF_INSTR),
   .RETURN_FROM_ISR_INSTR(RETURN_FROM_ISR_INSTR),
   .TRAP_INSTR(TRAP_INSTR), .VEC_REQ(VEC_REQ), .VEC_ADDR(VEC_ADDR),
   .PUSH_RET(PUSH_RET), .WAKE(WAKE), .SLEEPING(SLEEPING), .GIE(GIE));

// >>> mic_irq_ctrl_tb.sv
// self-checking bench of the interrupt controller
`timescale 1ns/1ps
module mic_irq_ctrl_tb;
   import mic_pkg::*;
   // ************************************************************
   // stimulus and checks
   // ************************************************************
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic        hsel = 1'b0, hwrite = 1'b0, timer_ovf = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [7:0]  port_pin = 8'hFF;
   logic        hreadyout, hresp, vec_req, push_ret, wake, sleeping, gie;
   logic [9:0]  vec_addr;
   logic [2:0]  irq_active;
   logic [4:0]  instr;
   int          miscompares = 0, checked = 0, cycles = 0;
   initial forever #2 clk_sys = ~clk_sys;
   mic_irq_ctrl dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
      .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .TIMER_OVF(timer_ovf),
      .PORT_PIN(port_pin), .GLOBAL_IRQ_ON_INSTR(instr[0]),
      .GLOBAL_IRQ_OFF_INSTR(instr[1]), .RETURN_FROM_ISR_INSTR(instr[2]),
      .SLEEP_INSTR(instr[3]), .TRAP_INSTR(instr[4]), .VEC_REQ(vec_req),
      .VEC_ADDR(vec_addr), .PUSH_RET(push_ret), .WAKE(wake),
      .SLEEPING(sleeping), .GIE(gie), .IRQ_ACTIVE(irq_active));
   mic_core_model core (.clk(clk_sys), .rst(sys_rst), .vec_req(vec_req),
      .push_ret(push_ret), .vec_addr(vec_addr), .wake(wake), .instr(instr));
   task results;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results
   // hang guard, far beyond the few hundred cycles the run needs
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         results();
      end
   end
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : cyc
   // one single transfer; the slave sets the pace through hreadyout
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(nm, q, e);
   endtask : rc
   task tmr;
      @(posedge clk_sys);
      timer_ovf <= 1'b1;
      @(posedge clk_sys);
      timer_ovf <= 1'b0;
   endtask : tmr
   task wait_vec(input int n);
      for (int i = 0; i < 40 && core.vec_cnt < n; i++) @(posedge clk_sys);
      chk("vector count", core.vec_cnt, n);
   endtask : wait_vec
   // main sequence: each block leaves flags clear and pins at reference
   initial begin
      cyc(6);
      sys_rst <= 1'b0;
      rc("flag", MIC_OFS_FLAG, 32'h0);
      rc("mask", MIC_OFS_MASK, 32'h0);
      rc("pcfg", MIC_OFS_PCFG, {23'h0, MIC_RST_ALT, MIC_RST_DIR});
      rc("stat", MIC_OFS_STAT, 32'h0);
      rc("hole", 8'h20, 32'h0);
      tmr();
      cyc(3);
      rc("timer flag", MIC_OFS_FLAG, 32'h1 << MIC_BIT_TMR);
      chk("active masked", 32'(irq_active), 32'h0);
      wr(MIC_OFS_FLAG, 32'h0);
      rc("port", MIC_OFS_PORT, 32'hFF);
      port_pin[5] <= 1'b0;
      cyc(5);
      rc("pchg unmasked", MIC_OFS_FLAG, 32'h0);
      port_pin[5] <= 1'b1;
      wr(MIC_OFS_PCFG, 32'hF7);
      wr(MIC_OFS_MASK, 32'h1 << MIC_BIT_PCHG);
      port_pin[3] <= 1'b0;
      cyc(5);
      rc("output pin", MIC_OFS_FLAG, 32'h0);
      port_pin[4] <= 1'b0;
      cyc(5);
      rc("input pin", MIC_OFS_FLAG, 32'h1 << MIC_BIT_PCHG);
      chk("active pchg", 32'(irq_active), 32'h1 << MIC_BIT_PCHG);
      port_pin <= 8'hFF;
      cyc(5);
      wr(MIC_OFS_FLAG, 32'h0);
      wr(MIC_OFS_PCFG, 32'h1FF);
      port_pin[0] <= 1'b0;
      cyc(6);
      rc("ext flag", MIC_OFS_FLAG, 32'h1 << MIC_BIT_EXT);
      port_pin[0] <= 1'b1;
      cyc(5);
      wr(MIC_OFS_FLAG, 32'h0);
      wr(MIC_OFS_MASK, 32'h1 << MIC_BIT_TMR);
      core.issue(0);
      cyc(3);
      chk("gie on", 32'(gie), 32'h1);
      tmr();
      wait_vec(1);
      chk("irq addr", 32'(core.last_vec), 32'(MIC_VEC_IRQ));
      cyc(2);
      chk("gie cleared", 32'(gie), 32'h0);
      chk("stack", core.depth, 32'h1);
      rc("poll", MIC_OFS_FLAG, 32'h1 << MIC_BIT_TMR);
      wr(MIC_OFS_FLAG, 32'h0);
      core.issue(2);
      cyc(3);
      chk("gie return", 32'(gie), 32'h1);
      core.issue(1);
      cyc(3);
      chk("gie off", 32'(gie), 32'h0);
      tmr();
      cyc(10);
      chk("no vector", core.vec_cnt, 32'h1);
      wr(MIC_OFS_FLAG, 32'h0);
      core.issue(0);
      core.issue(4);
      wait_vec(2);
      chk("trap addr", 32'(core.last_vec), 32'(MIC_VEC_TRAP));
      // the trap vector cleared the global enable, so a second trap is lost
      core.issue(4);
      cyc(5);
      chk("trap ignored", core.vec_cnt, 32'h2);
      wr(MIC_OFS_MASK, 32'h1 << MIC_BIT_PCHG);
      rc("port", MIC_OFS_PORT, 32'hFF);
      core.issue(3);
      cyc(3);
      chk("asleep", 32'(sleeping), 32'h1);
      rc("stat armed", MIC_OFS_STAT,
         (32'h1 << MIC_BIT_SLP) | (32'h1 << MIC_BIT_ARM));
      port_pin[6] <= 1'b0;
      cyc(10);
      chk("woken", core.wake_cnt, 32'h1);
      chk("in line", core.vec_cnt, 32'h2);
      port_pin[6] <= 1'b1;
      cyc(5);
      wr(MIC_OFS_FLAG, 32'h0);
      core.issue(0);
      core.issue(3);
      cyc(3);
      port_pin[6] <= 1'b0;
      wait_vec(3);
      chk("wake addr", 32'(core.last_vec), 32'(MIC_VEC_IRQ));
      port_pin[6] <= 1'b1;
      cyc(5);
      wr(MIC_OFS_FLAG, 32'h0);
      wr(MIC_OFS_MASK, 32'h0);
      core.issue(3);
      port_pin[6] <= 1'b0;
      cyc(10);
      chk("no wake", core.wake_cnt, 32'h2);
      rc("stat asleep", MIC_OFS_STAT, 32'h1 << MIC_BIT_SLP);
      results();
   end
endmodule : mic_irq_ctrl_tb

// >>> mic_pkg.sv
// shared constants and types of the interrupt controller
package mic_pkg;

   // ************************************************************
   // register map (byte addresses on the AHB-Lite slave)
   // ************************************************************
   localparam logic [7:0] MIC_OFS_FLAG   = 8'h00; // irq_flag_reg
   localparam logic [7:0] MIC_OFS_MASK   = 8'h04; // irq_mask_reg
   localparam logic [7:0] MIC_OFS_PCFG   = 8'h08; // port direction + alt sel
   localparam logic [7:0] MIC_OFS_STAT   = 8'h0C; // core-facing status
   localparam logic [7:0] MIC_OFS_PORT   = 8'h10; // port read, refreshes ref

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int MIC_SRC_NUM   = 3;
   localparam int MIC_BIT_TMR   = 0;  // timer_counter overflow
   localparam int MIC_BIT_PCHG  = 1;  // pin_change_flag
   localparam int MIC_BIT_EXT   = 2;  // external pin
   localparam int MIC_BIT_ALT   = 8;  // pcfg: pin 0 is port_pin_zero_alt
   localparam int MIC_BIT_GIE   = 0;  // stat fields
   localparam int MIC_BIT_SLP   = 1;
   localparam int MIC_BIT_ARM   = 2;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [2:0] MIC_RST_FLAG  = 3'h0;
   localparam logic [2:0] MIC_RST_MASK  = 3'h0;
   localparam logic [7:0] MIC_RST_DIR   = 8'hFF; // all pins input
   localparam logic       MIC_RST_ALT   = 1'b0;

   // ************************************************************
   // vectors
   // ************************************************************
   localparam int         MIC_PC_W      = 10;
   localparam logic [9:0] MIC_VEC_IRQ   = 10'h008;
   localparam logic [9:0] MIC_VEC_TRAP  = 10'h001;

   // power state of the core
   typedef enum logic [1:0] {
      MIC_ST_RUN   = 2'b01,
      MIC_ST_SLEEP = 2'b10
   } mic_state_type;

endpackage : mic_pkg
